/* File: hdl/otpr_regs.svh */
`ifndef OTPR_REGS_SVH
`define OTPR_REGS_SVH

// Control byte upper nibbles
`define OTPR_CODE_MAIN 4'hA
`define OTPR_CODE_SEC 4'hB
// Chip select bits carried in the control byte
`define OTPR_DEV_SEL 3'h0

// Device address map
`define OTPR_WP_ADDR 16'h0401
`define OTPR_WP_RESET 8'h00
`define OTPR_SEC_HI_ZERO 9'h000
`define OTPR_SEC_USER_WORDS 64
`define OTPR_FILL_BYTE 8'hFF
`define OTPR_MAIN_DEPTH 8192

// Controller register offsets (byte addresses)
`define OTPR_REG_CTRL 8'h00
`define OTPR_REG_ADDR 8'h04
`define OTPR_REG_LEN 8'h08
`define OTPR_REG_WDATA 8'h0C
`define OTPR_REG_STATUS 8'h10
`define OTPR_REG_RXDATA 8'h14

// Controller field positions
`define OTPR_CTRL_SEC_BIT 2
`define OTPR_STAT_BUSY_BIT 0
`define OTPR_STAT_NACK_BIT 1
`define OTPR_STAT_LEVEL_LSB 8
`define OTPR_RX_VALID_BIT 8

// Serial clock timing: quarter of a 1 MHz bit period, least time
`define OTPR_CLK_MHZ 125
`define OTPR_QTR_NS 250
`define OTPR_QTR_CYC ((`OTPR_QTR_NS * `OTPR_CLK_MHZ + 999) / 1000)

// Receive buffer
`define OTPR_FIFO_DEPTH 32

`endif

/* File: hdl/otpr_pkg.sv */
`default_nettype none

package otpr_pkg;

	typedef enum logic [1:0] {
		OTPR_OP_CUR,
		OTPR_OP_RAND,
		OTPR_OP_WRITE
	} otpr_op_t;

	typedef enum logic [2:0] {
		OTPR_D_IDLE,
		OTPR_D_CTRL,
		OTPR_D_AHI,
		OTPR_D_ALO,
		OTPR_D_WDAT,
		OTPR_D_SEND,
		OTPR_D_MACK
	} otpr_dev_st_t;

	typedef enum logic [2:0] {
		OTPR_H_IDLE,
		OTPR_H_START,
		OTPR_H_TX,
		OTPR_H_RX,
		OTPR_H_STOP
	} otpr_host_st_t;

	typedef enum logic [2:0] {
		OTPR_ROLE_CTRLW,
		OTPR_ROLE_AHI,
		OTPR_ROLE_ALO,
		OTPR_ROLE_WDAT,
		OTPR_ROLE_CTRLR
	} otpr_role_t;

endpackage

`default_nettype wire

/* File: hdl/otpr_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface otpr_if;
	logic scl_o;
	logic scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Open-drain wired-AND with pull-ups
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport host (
		output scl_o,
		output scl_oe,
		output host_sda_o,
		output host_sda_oe,
		input scl,
		input sda
	);

	modport device (
		output dev_sda_o,
		output dev_sda_oe,
		input scl,
		input sda
	);
endinterface

`default_nettype wire

/* File: hdl/otpr_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module otpr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [$clog2(DEPTH+1)-1:0] FULL = ($clog2(DEPTH+1))'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic push;
	logic pop;

	assign in_ready = level != FULL;
	assign out_valid = level != '0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				level <= level + 1'b1;
			end else if (pop && !push) begin
				level <= level - 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

/* File: hdl/otpr_device.sv */
// Operation
// - Pointer holds last accessed location plus one
// - Read control byte: acknowledge, send byte at pointer
// - Master nack then STOP ends device driving
// - Master loads 0401h to read protection register
// - Repeated START abandons write, keeps loaded pointer
// - Same control byte with read bit returns byte
// - Protection register read advances pointer past it
// - One pointer shared by all three spaces
// - Master uses random read when switching spaces
// - Security reads need upper nine bits zero
// - Offsets 0-63 user, 64-127 factory section
// - Security random read advances pointer past byte
// - Master ack requests next sequential byte
// - Pointer increments per master ack and STOP
// - Whole security register streams in one read
// - Control nibble 1011 security, 1010 main array
`timescale 1ns/1ps
`default_nettype none
`include "otpr_regs.svh"

module otpr_device import otpr_pkg::*; #(
	parameter int MAIN_DEPTH = `OTPR_MAIN_DEPTH,
	parameter logic [2:0] DEV_SEL = `OTPR_DEV_SEL,
	// Arbitrary seed for the factory unique-value section
	parameter logic [7:0] UID_SEED = 8'h5A
) (
	input wire logic clk,
	input wire logic sys_rst,
	otpr_if.device bus,
	output logic [7:0] write_protection_setting,
	output logic [15:0] addr_ptr,
	output logic active
);
	localparam int AW = $clog2(MAIN_DEPTH);
	localparam logic [16:0] MAIN_LIMIT = 17'(MAIN_DEPTH);

	// Pin synchronisers: bit 1 is the clock line, bit 0 the data line
	logic [1:0] pin_raw;
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync3;
	logic [1:0] pin_val;
	logic [1:0] pin_prev;

	assign pin_raw = {bus.scl, bus.sda};

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync1 <= 2'h3;
			sync2 <= 2'h3;
			sync3 <= 2'h3;
			pin_prev <= 2'h3;
		end else begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			pin_prev <= pin_val;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					pin_val[gi] <= 1'b1;
				end else if (sync2[gi] == sync3[gi]) begin
					pin_val[gi] <= sync3[gi];
				end
			end
		end
	endgenerate

	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;

	assign scl = pin_val[1];
	assign sda = pin_val[0];
	assign scl_rise = scl && !pin_prev[1];
	assign scl_fall = !scl && pin_prev[1];
	assign start_ev = scl && pin_prev[1] && pin_prev[0] && !sda;
	assign stop_ev = scl && pin_prev[1] && !pin_prev[0] && sda;

	// Protocol state
	otpr_dev_st_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] addr_hi;
	logic [15:0] ptr;
	logic ack_ph;
	logic sec_space;
	logic rw;
	logic read_pend;
	logic sda_oe;

	// Storage
	logic [7:0] main_mem [MAIN_DEPTH];
	logic [7:0] user_mem [`OTPR_SEC_USER_WORDS];
	logic [7:0] wp_reg;
	logic [7:0] rd_byte;
	logic byte_done;
	logic ctrl_match;

	assign byte_done = scl_fall && !ack_ph && bit_cnt == 4'h8;
	assign ctrl_match = shift[7:1] == {`OTPR_CODE_MAIN, DEV_SEL}
		|| shift[7:1] == {`OTPR_CODE_SEC, DEV_SEL};

	// Byte presented at the shared pointer
	always_comb begin
		rd_byte = `OTPR_FILL_BYTE;
		if (sec_space) begin
			if (ptr[15:7] == `OTPR_SEC_HI_ZERO) begin
				if (ptr[6]) begin
					rd_byte = UID_SEED ^ {1'b0, ptr[6:0]};
				end else begin
					rd_byte = user_mem[ptr[5:0]];
				end
			end
		end else if (ptr == `OTPR_WP_ADDR) begin
			rd_byte = wp_reg;
		end else if ({1'b0, ptr} < MAIN_LIMIT) begin
			rd_byte = main_mem[ptr[AW-1:0]];
		end
	end

	// Write path for received data bytes
	always_ff @(posedge clk) begin
		if (byte_done && state == OTPR_D_WDAT && !sec_space
			&& {1'b0, ptr} < MAIN_LIMIT && ptr != `OTPR_WP_ADDR) begin
			main_mem[ptr[AW-1:0]] <= shift;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wp_reg <= `OTPR_WP_RESET;
			for (int i = 0; i < `OTPR_SEC_USER_WORDS; i++) begin
				user_mem[i] <= `OTPR_FILL_BYTE;
			end
		end else if (byte_done && state == OTPR_D_WDAT) begin
			if (!sec_space && ptr == `OTPR_WP_ADDR) begin
				wp_reg <= shift;
			end else if (sec_space && ptr[15:6] == 10'h000) begin
				user_mem[ptr[5:0]] <= shift;
			end
		end
	end

	// Serial protocol and the shared address pointer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= OTPR_D_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			addr_hi <= 8'h00;
			ptr <= 16'h0000;
			ack_ph <= 1'b0;
			sec_space <= 1'b0;
			rw <= 1'b0;
			read_pend <= 1'b0;
			sda_oe <= 1'b0;
		end else if (start_ev) begin
			// Pointer is left as loaded by an abandoned write
			state <= OTPR_D_CTRL;
			bit_cnt <= 4'h0;
			ack_ph <= 1'b0;
			sda_oe <= 1'b0;
			read_pend <= 1'b0;
		end else if (stop_ev) begin
			state <= OTPR_D_IDLE;
			ack_ph <= 1'b0;
			sda_oe <= 1'b0;
			if (read_pend) begin
				ptr <= ptr + 16'h0001;
				read_pend <= 1'b0;
			end
		end else begin
			unique case (state)
				OTPR_D_IDLE: begin
					sda_oe <= 1'b0;
				end
				OTPR_D_CTRL, OTPR_D_AHI, OTPR_D_ALO, OTPR_D_WDAT: begin
					if (scl_rise && !ack_ph) begin
						shift <= {shift[6:0], sda};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && ack_ph) begin
						ack_ph <= 1'b0;
						bit_cnt <= 4'h0;
						if (state == OTPR_D_CTRL && rw) begin
							state <= OTPR_D_SEND;
							sda_oe <= ~rd_byte[7];
							read_pend <= 1'b1;
						end else begin
							sda_oe <= 1'b0;
							state <= (state == OTPR_D_CTRL) ? OTPR_D_AHI
								: (state == OTPR_D_AHI) ? OTPR_D_ALO : OTPR_D_WDAT;
						end
					end else if (byte_done) begin
						if (state == OTPR_D_CTRL) begin
							if (ctrl_match) begin
								sec_space <= shift[7:4] == `OTPR_CODE_SEC;
								rw <= shift[0];
								sda_oe <= 1'b1;
								ack_ph <= 1'b1;
							end else begin
								state <= OTPR_D_IDLE;
							end
						end else begin
							sda_oe <= 1'b1;
							ack_ph <= 1'b1;
							if (state == OTPR_D_AHI) begin
								addr_hi <= shift;
							end else if (state == OTPR_D_ALO) begin
								ptr <= {addr_hi, shift};
							end else begin
								ptr <= ptr + 16'h0001;
							end
						end
					end
				end
				OTPR_D_SEND: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt == 4'h8) begin
							sda_oe <= 1'b0;
							state <= OTPR_D_MACK;
						end else begin
							sda_oe <= ~rd_byte[3'(4'h7 - bit_cnt)];
						end
					end
				end
				OTPR_D_MACK: begin
					if (scl_rise) begin
						if (!sda) begin
							// Every bit of the pointer moves, also in security space
							ptr <= ptr + 16'h0001;
							bit_cnt <= 4'h0;
							state <= OTPR_D_SEND;
						end else begin
							state <= OTPR_D_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = sda_oe;
	assign write_protection_setting = wp_reg;
	assign addr_ptr = ptr;
	assign active = state != OTPR_D_IDLE;
endmodule

`default_nettype wire

/* File: hdl/otpr_host.sv */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "otpr_regs.svh"

module otpr_host import otpr_pkg::*; #(
	parameter int QTR_CYC = `OTPR_QTR_CYC,
	parameter int FIFO_DEPTH = `OTPR_FIFO_DEPTH,
	parameter logic [2:0] DEV_SEL = `OTPR_DEV_SEL
) (
	input wire logic clk,
	input wire logic sys_rst,
	otpr_if.host bus,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata
);
	localparam int LW = $clog2(FIFO_DEPTH + 1);
	localparam logic [15:0] QTR_LAST = 16'(QTR_CYC - 1);

	// Quarter-bit enable
	logic [15:0] div_cnt;
	logic tick;
	assign tick = div_cnt == QTR_LAST;
	always_ff @(posedge clk) begin
		if (sys_rst || tick) begin
			div_cnt <= 16'h0000;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
		end
	end

	// Data line input synchroniser
	logic s1;
	logic s2;
	logic s3;
	logic sda_in;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			sda_in <= 1'b1;
		end else begin
			s1 <= bus.sda;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				sda_in <= s3;
			end
		end
	end

	// Software registers
	otpr_op_t op;
	logic sec;
	logic [15:0] mem_addr;
	logic [8:0] len;
	logic [7:0] wbyte;
	logic busy;
	logic nack_err;
	logic start_cmd;
	assign start_cmd = wr && addr == `OTPR_REG_CTRL && !busy;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			op <= OTPR_OP_CUR;
			sec <= 1'b0;
			mem_addr <= 16'h0000;
			len <= 9'h001;
			wbyte <= 8'h00;
		end else if (wr) begin
			if (start_cmd) begin
				op <= (wdata[1:0] == 2'h3) ? OTPR_OP_CUR : otpr_op_t'(wdata[1:0]);
				sec <= wdata[`OTPR_CTRL_SEC_BIT];
			end
			if (addr == `OTPR_REG_ADDR) begin
				mem_addr <= wdata[15:0];
			end
			if (addr == `OTPR_REG_LEN) begin
				len <= wdata[8:0];
			end
			if (addr == `OTPR_REG_WDATA) begin
				wbyte <= wdata[7:0];
			end
		end
	end

	// Receive buffer
	logic [7:0] rx_sh;
	logic push;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [7:0] fifo_out_data;
	logic [LW-1:0] fifo_level;
	assign fifo_pop = rd && addr == `OTPR_REG_RXDATA;

	otpr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(rx_sh),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			rdata <= 32'h00000000;
			case (addr)
				`OTPR_REG_CTRL: rdata <= {29'h0, sec, op};
				`OTPR_REG_ADDR: rdata <= {16'h0000, mem_addr};
				`OTPR_REG_LEN: rdata <= {23'h0, len};
				`OTPR_REG_WDATA: rdata <= {24'h0, wbyte};
				`OTPR_REG_STATUS: rdata <= {16'h0000, 8'(fifo_level), 6'h0, nack_err, busy};
				`OTPR_REG_RXDATA: rdata <= {23'h0, fifo_out_valid, fifo_out_data};
				default: rdata <= 32'h00000000;
			endcase
		end
	end

	// Bit engine: q0 set data, q1 clock high, q2 sample, q3 clock low
	otpr_host_st_t hst;
	otpr_role_t role;
	logic [1:0] q;
	logic [3:0] bitn;
	logic [7:0] tx;
	logic [8:0] remain;
	logic ack_bit;
	logic scl_low;
	logic sda_low;
	logic [3:0] code;
	logic stall;
	assign code = sec ? `OTPR_CODE_SEC : `OTPR_CODE_MAIN;
	assign push = tick && hst == OTPR_H_RX && q == 2'h3 && bitn == 4'h7;
	// Hold the clock low before a byte while the buffer has no room
	assign stall = hst == OTPR_H_RX && q == 2'h0 && bitn == 4'h0 && !fifo_in_ready;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hst <= OTPR_H_IDLE;
			role <= OTPR_ROLE_CTRLW;
			q <= 2'h0;
			bitn <= 4'h0;
			tx <= 8'h00;
			remain <= 9'h001;
			ack_bit <= 1'b1;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			busy <= 1'b0;
			nack_err <= 1'b0;
			rx_sh <= 8'h00;
		end else if (start_cmd) begin
			busy <= 1'b1;
			nack_err <= 1'b0;
			hst <= OTPR_H_START;
			q <= 2'h0;
			// Random read and write load the pointer first
			role <= (wdata[1:0] == 2'h1 || wdata[1:0] == 2'h2)
				? OTPR_ROLE_CTRLW : OTPR_ROLE_CTRLR;
			if (len == 9'h000) begin
				remain <= 9'h001;
			end else begin
				remain <= len;
			end
		end else if (tick && !stall) begin
			q <= q + 2'h1;
			unique case (hst)
				OTPR_H_IDLE: begin
					q <= 2'h0;
				end
				OTPR_H_START: begin
					if (q == 2'h0) sda_low <= 1'b0;
					if (q == 2'h1) scl_low <= 1'b0;
					if (q == 2'h2) sda_low <= 1'b1;
					if (q == 2'h3) begin
						scl_low <= 1'b1;
						hst <= OTPR_H_TX;
						bitn <= 4'h0;
						tx <= {code, DEV_SEL, role == OTPR_ROLE_CTRLR};
					end
				end
				OTPR_H_TX: begin
					if (q == 2'h0) sda_low <= (bitn == 4'h8) ? 1'b0 : ~tx[3'(4'h7 - bitn)];
					if (q == 2'h1) scl_low <= 1'b0;
					if (q == 2'h2 && bitn == 4'h8) ack_bit <= sda_in;
					if (q == 2'h3) begin
						scl_low <= 1'b1;
						bitn <= bitn + 4'h1;
						if (bitn == 4'h8) begin
							bitn <= 4'h0;
							if (ack_bit) begin
								nack_err <= 1'b1;
								hst <= OTPR_H_STOP;
							end else begin
								unique case (role)
									OTPR_ROLE_CTRLW: begin
										role <= OTPR_ROLE_AHI;
										tx <= mem_addr[15:8];
									end
									OTPR_ROLE_AHI: begin
										role <= OTPR_ROLE_ALO;
										tx <= mem_addr[7:0];
									end
									OTPR_ROLE_ALO: begin
										if (op == OTPR_OP_WRITE) begin
											role <= OTPR_ROLE_WDAT;
											tx <= wbyte;
										end else begin
											role <= OTPR_ROLE_CTRLR;
											hst <= OTPR_H_START;
										end
									end
									OTPR_ROLE_WDAT: hst <= OTPR_H_STOP;
									OTPR_ROLE_CTRLR: hst <= OTPR_H_RX;
								endcase
							end
						end
					end
				end
				OTPR_H_RX: begin
					if (q == 2'h0) sda_low <= (bitn == 4'h8) && remain > 9'h001;
					if (q == 2'h1) scl_low <= 1'b0;
					if (q == 2'h2 && bitn != 4'h8) rx_sh <= {rx_sh[6:0], sda_in};
					if (q == 2'h3) begin
						scl_low <= 1'b1;
						bitn <= bitn + 4'h1;
						if (bitn == 4'h8) begin
							bitn <= 4'h0;
							if (remain > 9'h001) begin
								remain <= remain - 9'h001;
							end else begin
								hst <= OTPR_H_STOP;
							end
						end
					end
				end
				OTPR_H_STOP: begin
					if (q == 2'h0) sda_low <= 1'b1;
					if (q == 2'h1) scl_low <= 1'b0;
					if (q == 2'h2) sda_low <= 1'b0;
					if (q == 2'h3) begin
						hst <= OTPR_H_IDLE;
						busy <= 1'b0;
					end
				end
			endcase
		end
	end

	assign bus.scl_o = 1'b0;
	assign bus.scl_oe = scl_low;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe = sda_low;
endmodule

`default_nettype wire

/* File: bench/otpr_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "otpr_regs.svh"

module otpr_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q;
	logic sda_q;
	logic [3:0] bitn;
	logic [7:0] byten;
	logic [7:0] sh;
	logic rdf;
	logic nacked;
	logic rise_c;
	logic start_c;
	logic stop_c;

	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	assign rise_c = scl && !scl_q;
	assign start_c = scl && scl_q && sda_q && !sda;
	assign stop_c = scl && scl_q && !sda_q && sda;

	always_ff @(posedge clk) begin
		scl_q <= sys_rst || scl;
		sda_q <= sys_rst || sda;
	end

	// Bit and byte position within the current frame
	always_ff @(posedge clk) begin
		if (sys_rst || start_c || stop_c) begin
			bitn <= 4'h0;
			byten <= 8'h00;
			rdf <= 1'b0;
		end else if (rise_c) begin
			bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
			if (bitn == 4'h8) begin
				byten <= byten + 8'h01;
			end
			if (bitn == 4'h7 && byten == 8'h00) begin
				rdf <= sda;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sh <= 8'h00;
		end else if (rise_c) begin
			sh <= {sh[6:0], sda};
		end
	end

	// Master left a read byte unacknowledged
	always_ff @(posedge clk) begin
		if (sys_rst || start_c || stop_c) begin
			nacked <= 1'b0;
		end else if (rise_c && bitn == 4'h8 && rdf && byten != 8'h00 && sda) begin
			nacked <= 1'b1;
		end
	end

	rst_idle_a: assert property (
		$fell(sys_rst) |-> !scl_oe && !host_sda_oe && !dev_sda_oe)
		else $error("Bus lines held after reset");
	dev_low_edge_a: assert property (
		$changed(dev_sda_oe) |-> !scl)
		else $error("Device moved data while clock high");
	ctrl_ack_a: assert property (
		rise_c && bitn == 4'h8 && byten == 8'h00
		&& (sh[7:1] == {`OTPR_CODE_MAIN, `OTPR_DEV_SEL} || sh[7:1] == {`OTPR_CODE_SEC, `OTPR_DEV_SEL})
		|-> !sda)
		else $error("Control byte not acknowledged");
	addr_ack_a: assert property (
		rise_c && bitn == 4'h8 && !rdf && byten != 8'h00 && byten < 8'h04 |-> !sda)
		else $error("Address or data byte not acknowledged");
	master_ack_a: assert property (
		rise_c && bitn == 4'h8 && rdf && byten != 8'h00 |-> !dev_sda_oe)
		else $error("Device drove data in master ack slot");
	nack_release_a: assert property (
		nacked |-> !dev_sda_oe)
		else $error("Device drove data after master nack");
	stop_quiet_a: assert property (
		stop_c |=> (!dev_sda_oe)[*8])
		else $error("Device drove data after stop");
	start_free_a: assert property (
		start_c |-> !dev_sda_oe)
		else $error("Device held data at start");
endmodule

`default_nettype wire

/* File: bench/otp_and_protect_reg_read_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "otpr_regs.svh"

module otp_and_protect_reg_read_bench import otpr_pkg::*; ;
	localparam logic [7:0] UID = 8'h5A;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [7:0] wp_val;
	logic [15:0] ptr;
	logic active;
	int mismatches = 0;
	int n_tests = 0;

	otpr_if otpr_if_inst();
	otpr_host #(.QTR_CYC(8)) otpr_host_inst (.clk(clk), .sys_rst(sys_rst), .bus(otpr_if_inst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	otpr_device #(.UID_SEED(UID)) otpr_device_inst (.clk(clk), .sys_rst(sys_rst),
		.bus(otpr_if_inst), .write_protection_setting(wp_val), .addr_ptr(ptr), .active(active));
	otpr_monitor otpr_monitor_inst (.clk(clk), .sys_rst(sys_rst), .scl_oe(otpr_if_inst.scl_oe),
		.host_sda_oe(otpr_if_inst.host_sda_oe), .dev_sda_oe(otpr_if_inst.dev_sda_oe),
		.scl(otpr_if_inst.scl), .sda(otpr_if_inst.sda));

	initial begin
		forever #4 clk = ~clk;
	end

	task automatic summarize();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic start(input otpr_op_t op, input logic sec, input logic [15:0] a,
		input logic [8:0] len);
		wr_reg(`OTPR_REG_ADDR, {16'h0, a});
		wr_reg(`OTPR_REG_LEN, {23'h0, len});
		wr_reg(`OTPR_REG_CTRL, {29'h0, sec, op});
	endtask

	task automatic wait_idle();
		logic [31:0] st;
		int n;
		repeat (2) @(posedge clk);
		st = 32'h1;
		for (n = 0; n < 5000 && st[0] !== 1'b0; n++) rd_reg(`OTPR_REG_STATUS, st);
		check({31'h0, st[0]}, 32'h0);
		// Let the device see STOP through its synchroniser
		repeat (8) @(posedge clk);
		check({31'h0, active}, 32'h0);
	endtask

	task automatic pop(input logic [7:0] exp);
		logic [31:0] d;
		rd_reg(`OTPR_REG_RXDATA, d);
		check({23'h0, d[8:0]}, {23'h0, 1'b1, exp});
	endtask

	task automatic t_reset();
		logic [31:0] d;
		check({16'h0, ptr}, 32'h0);
		check({24'h0, wp_val}, 32'h0);
		rd_reg(8'h1C, d);
		check(d, 32'h0);
		rd_reg(`OTPR_REG_STATUS, d);
		check({16'h0, d[15:0]}, 32'h0);
	endtask

	task automatic t_wp();
		wr_reg(`OTPR_REG_WDATA, 32'hA5);
		start(OTPR_OP_WRITE, 1'b0, `OTPR_WP_ADDR, 9'h001);
		wait_idle();
		check({24'h0, wp_val}, 32'hA5);
		wr_reg(`OTPR_REG_WDATA, 32'h3C);
		start(OTPR_OP_WRITE, 1'b0, 16'h0400, 9'h001);
		wait_idle();
		check({16'h0, ptr}, 32'h401);
		start(OTPR_OP_CUR, 1'b0, 16'h0000, 9'h001);
		wait_idle();
		pop(8'hA5);
		check({16'h0, ptr}, 32'h402);
		start(OTPR_OP_RAND, 1'b0, `OTPR_WP_ADDR, 9'h001);
		wait_idle();
		pop(8'hA5);
		check({16'h0, ptr}, 32'h402);
		start(OTPR_OP_RAND, 1'b0, 16'h0400, 9'h002);
		wait_idle();
		pop(8'h3C);
		pop(8'hA5);
		check({16'h0, ptr}, 32'h402);
		start(OTPR_OP_CUR, 1'b1, 16'h0000, 9'h001);
		wait_idle();
		pop(`OTPR_FILL_BYTE);
		check({16'h0, ptr}, 32'h403);
	endtask

	task automatic t_sec();
		start(OTPR_OP_RAND, 1'b1, 16'h0040, 9'h001);
		wait_idle();
		pop(UID ^ 8'h40);
		check({16'h0, ptr}, 32'h41);
		start(OTPR_OP_CUR, 1'b1, 16'h0000, 9'h001);
		wait_idle();
		pop(UID ^ 8'h41);
		check({16'h0, ptr}, 32'h42);
	endtask

	task automatic t_stream();
		logic [31:0] st;
		int k;
		int n;
		start(OTPR_OP_RAND, 1'b1, 16'h0000, 9'h080);
		st = 32'h0;
		for (n = 0; n < 20000 && st[15:8] !== 8'h20; n++) rd_reg(`OTPR_REG_STATUS, st);
		check({24'h0, st[15:8]}, 32'h20);
		check({31'h0, st[0]}, 32'h1);
		check({31'h0, active}, 32'h1);
		// A start order while busy must leave the running command alone
		wr_reg(`OTPR_REG_CTRL, 32'h0);
		rd_reg(`OTPR_REG_CTRL, st);
		check(st, 32'h5);
		for (k = 0; k < 128; k++) begin
			st = 32'h0;
			for (n = 0; n < 2000 && st[15:8] === 8'h00; n++) rd_reg(`OTPR_REG_STATUS, st);
			pop(k < 64 ? 8'hFF : UID ^ k[7:0]);
		end
		wait_idle();
		check({16'h0, ptr}, 32'h80);
		rd_reg(`OTPR_REG_RXDATA, st);
		check({31'h0, st[8]}, 32'h0);
	endtask

	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		summarize();
	end

	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_wp();
		t_sec();
		t_stream();
		summarize();
	end
endmodule

`default_nettype wire
